// ### src/pfs_supervisor.sv
// protection supervisor: limit checks, trip qualification, fault latch and clear
// assumes meter words on clk_i, panel keys and rear clear line asynchronous
// What this block does
// - enabled overcurrent trips after current exceeds limit longer than delay
// - enabled overpower trips after power exceeds limit longer than delay
// - enabled undervoltage trips only after warm-up and delay both elapse
// - undervoltage ignored during warm-up while output voltage rises
// - violations shorter than delay ignored; trip only if still present
// - each limit function has its own enable; disabled never trips
// - any fault turns output off, lights fault and off, beeps if enabled
// - fault display: row one meter voltage and current, row two cause
// - fault stays latched after cause disappears until cleared
// - pulse on rear fault clear input clears the fault record
// - escape or enter key clears the fault record
// - host fault-clear command clears the fault record
// - clearing leaves output off until output key or remote enable
// - signed current limit applies same magnitude in both directions
// - signed power limit applies same magnitude sourcing and absorbing
// - above about 90 C output off, fault lit, over-temperature shown
// - temperature threshold fixed, always checked, no enable
// - sense-reversal check active whenever remote sensing and output are both on
// - sense gap beyond threshold with output on trips after 500 ms
`include "pfs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pfs_supervisor #(
  parameter int MW = 24,
  parameter int TW = 12,
  parameter int TICK_CYC = `PFS_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic signed [MW-1:0] meter_v_i,
  input wire logic signed [MW-1:0] meter_i_i,
  input wire logic signed [MW-1:0] meter_p_i,
  input wire logic signed [MW-1:0] term_v_i,
  input wire logic [TW-1:0] temp_degc_i,
  input wire logic fault_clear_input_i,
  input wire logic key_esc_i,
  input wire logic key_enter_i,
  input wire logic key_onoff_i,
  output logic output_on_o,
  output logic led_prot_o,
  output logic led_off_o,
  output logic buzzer_o,
  output logic [2:0] disp_cause_o,
  output logic signed [MW-1:0] disp_v_o,
  output logic signed [MW-1:0] disp_i_o,
  output logic disp_fault_o
);
  initial begin
    if (MW < 2 || MW > 32 || TW < 8 || TW > 32 || TICK_CYC < 1) $error("pfs_supervisor: bad parameter");
  end

  localparam logic [31:0] TICK_MAX = 32'(TICK_CYC - 1);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [MW-1:0] oc_lim;
    logic [MW-1:0] op_lim;
    logic [MW-1:0] uv_lim;
    logic [MW-1:0] sense_th;
    logic [15:0] oc_dly;
    logic [15:0] op_dly;
    logic [15:0] uv_dly;
    logic [15:0] uv_warm;
    logic [31:0] tick_cnt;
    logic [15:0] oc_cnt;
    logic [15:0] op_cnt;
    logic [15:0] uv_cnt;
    logic [15:0] warm_cnt;
    logic [15:0] sense_cnt;
    logic [2:0] clr_s1;
    logic [2:0] clr_s2;
    logic [2:0] clr_d;
    logic on_s1;
    logic on_s2;
    logic on_d;
    logic out_on;
    logic out_off;
    logic latched;
    pfs_pkg::pfs_cause_t cause;
    logic buzz;
    logic [MW-1:0] hold_v;
    logic [MW-1:0] hold_i;
    logic ack;
    logic [31:0] rdat;
  } pfs_state_t;

  pfs_state_t s_r;
  pfs_state_t s_nxt;

  // magnitude helper so signed limits act symmetrically
  function automatic logic [MW-1:0] mag(input logic signed [MW-1:0] x);
    mag = x[MW-1] ? MW'(-x) : MW'(x);
  endfunction : mag

  logic tick;
  logic oc_viol;
  logic op_viol;
  logic uv_viol;
  logic ot_viol;
  logic sense_viol;
  logic warm_done;
  logic [2:0] clr_rise;
  logic clear_req;
  logic on_req;
  logic off_req;
  logic bus_hit;
  logic [MW-1:0] gap;

  always_comb begin
    tick = (s_r.tick_cnt == TICK_MAX);
    oc_viol = s_r.ctrl[`PFS_CTRL_OC_EN] && (mag(meter_i_i) > mag(s_r.oc_lim));
    op_viol = s_r.ctrl[`PFS_CTRL_OP_EN] && (mag(meter_p_i) > mag(s_r.op_lim));
    uv_viol = s_r.ctrl[`PFS_CTRL_UV_EN] && s_r.out_on && (meter_v_i < $signed(s_r.uv_lim));
    warm_done = (s_r.warm_cnt >= s_r.uv_warm);
    ot_viol = (temp_degc_i > TW'(`PFS_OT_DEGC));
    gap = mag(MW'(term_v_i - meter_v_i));
    sense_viol = s_r.ctrl[`PFS_CTRL_SENSE_ON] && s_r.out_on && (gap > s_r.sense_th);
    clr_rise = s_r.clr_s2 & ~s_r.clr_d;
    bus_hit = wb_cyc_i && wb_stb_i && !s_r.ack;
  end

  // bus access, event detection, counters and fault latch
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = bus_hit;
    s_nxt.clr_s1 = {key_enter_i, key_esc_i, fault_clear_input_i};
    s_nxt.clr_s2 = s_r.clr_s1;
    s_nxt.clr_d = s_r.clr_s2;
    s_nxt.on_s1 = key_onoff_i;
    s_nxt.on_s2 = s_r.on_s1;
    s_nxt.on_d = s_r.on_s2;
    s_nxt.tick_cnt = tick ? 32'h0000_0000 : s_r.tick_cnt + 32'h0000_0001;
    clear_req = |clr_rise;
    on_req = s_r.on_s2 && !s_r.on_d;
    off_req = 1'b0;
    s_nxt.rdat = 32'h0000_0000;
    if (bus_hit && wb_we_i && (&wb_sel_i)) begin
      unique case (wb_adr_i)
        `PFS_ADR_CTRL: s_nxt.ctrl = wb_dat_i;
        `PFS_ADR_OC_LIM: s_nxt.oc_lim = wb_dat_i[MW-1:0];
        `PFS_ADR_OP_LIM: s_nxt.op_lim = wb_dat_i[MW-1:0];
        `PFS_ADR_UV_LIM: s_nxt.uv_lim = wb_dat_i[MW-1:0];
        `PFS_ADR_OC_DLY: s_nxt.oc_dly = wb_dat_i[15:0];
        `PFS_ADR_OP_DLY: s_nxt.op_dly = wb_dat_i[15:0];
        `PFS_ADR_UV_DLY: s_nxt.uv_dly = wb_dat_i[15:0];
        `PFS_ADR_UV_WARM: s_nxt.uv_warm = wb_dat_i[15:0];
        `PFS_ADR_SENSE_TH: s_nxt.sense_th = wb_dat_i[MW-1:0];
        `PFS_ADR_CMD: begin
          clear_req = clear_req | wb_dat_i[`PFS_CMD_CLEAR];
          on_req = on_req | wb_dat_i[`PFS_CMD_OUT_ON];
          off_req = wb_dat_i[`PFS_CMD_OUT_OFF];
        end
        default: ;
      endcase
    end else if (bus_hit) begin
      // unmapped reads answer zero, the bus never stalls
      unique case (wb_adr_i)
        `PFS_ADR_CTRL: s_nxt.rdat = s_r.ctrl;
        `PFS_ADR_OC_LIM: s_nxt.rdat = 32'($signed(s_r.oc_lim));
        `PFS_ADR_OP_LIM: s_nxt.rdat = 32'($signed(s_r.op_lim));
        `PFS_ADR_UV_LIM: s_nxt.rdat = 32'($signed(s_r.uv_lim));
        `PFS_ADR_OC_DLY: s_nxt.rdat = {16'h0000, s_r.oc_dly};
        `PFS_ADR_OP_DLY: s_nxt.rdat = {16'h0000, s_r.op_dly};
        `PFS_ADR_UV_DLY: s_nxt.rdat = {16'h0000, s_r.uv_dly};
        `PFS_ADR_UV_WARM: s_nxt.rdat = {16'h0000, s_r.uv_warm};
        `PFS_ADR_SENSE_TH: s_nxt.rdat = 32'(s_r.sense_th);
        `PFS_ADR_STATUS: s_nxt.rdat = {25'h0, s_r.buzz, s_r.out_on, s_r.latched, 1'b0, 3'(s_r.cause)};
        `PFS_ADR_METER_V: s_nxt.rdat = 32'(meter_v_i);
        `PFS_ADR_METER_I: s_nxt.rdat = 32'(meter_i_i);
        `PFS_ADR_METER_P: s_nxt.rdat = 32'(meter_p_i);
        default: s_nxt.rdat = 32'h0000_0000;
      endcase
    end

    // warm-up runs from output turn-on, undervoltage is masked until then
    if (!s_r.out_on) begin
      s_nxt.warm_cnt = 16'h0000;
    end else if (tick && !warm_done) begin
      s_nxt.warm_cnt = s_r.warm_cnt + 16'h0001;
    end

    // delay timers restart whenever a violation drops out
    s_nxt.oc_cnt = !oc_viol ? 16'h0000 : (tick && s_r.oc_cnt <= s_r.oc_dly) ? s_r.oc_cnt + 16'h0001 : s_r.oc_cnt;
    s_nxt.op_cnt = !op_viol ? 16'h0000 : (tick && s_r.op_cnt <= s_r.op_dly) ? s_r.op_cnt + 16'h0001 : s_r.op_cnt;
    s_nxt.uv_cnt = !(uv_viol && warm_done) ? 16'h0000 :
                   (tick && s_r.uv_cnt <= s_r.uv_dly) ? s_r.uv_cnt + 16'h0001 : s_r.uv_cnt;
    s_nxt.sense_cnt = !sense_viol ? 16'h0000 :
                      (tick && s_r.sense_cnt < 16'(`PFS_SENSE_TICKS)) ? s_r.sense_cnt + 16'h0001 : s_r.sense_cnt;

    // clear first so a trip in the same cycle still latches
    if (clear_req) begin
      s_nxt.latched = 1'b0;
      s_nxt.cause = pfs_pkg::pfs_none;
      s_nxt.buzz = 1'b0;
    end
    if (on_req && !s_r.latched && !clear_req) s_nxt.out_on = 1'b1;
    if (off_req) s_nxt.out_on = 1'b0;

    // fixed priority when several causes trip together
    if (!s_r.latched || clear_req) begin
      if (ot_viol) s_nxt.cause = pfs_pkg::pfs_overtemp;
      else if (s_r.sense_cnt >= 16'(`PFS_SENSE_TICKS)) s_nxt.cause = pfs_pkg::pfs_sense_err;
      else if (oc_viol && s_r.oc_cnt > s_r.oc_dly) s_nxt.cause = pfs_pkg::pfs_overcurrent;
      else if (op_viol && s_r.op_cnt > s_r.op_dly) s_nxt.cause = pfs_pkg::pfs_overpower;
      else if (uv_viol && warm_done && s_r.uv_cnt > s_r.uv_dly) s_nxt.cause = pfs_pkg::pfs_undervoltage;
      if (s_nxt.cause != pfs_pkg::pfs_none) begin
        s_nxt.latched = 1'b1;
        s_nxt.out_on = 1'b0;
        s_nxt.buzz = s_r.ctrl[`PFS_CTRL_BEEP_EN];
        s_nxt.hold_v = meter_v_i;
        s_nxt.hold_i = meter_i_i;
      end
    end
    if (s_r.latched && !clear_req) begin
      s_nxt.hold_v = meter_v_i;
      s_nxt.hold_i = meter_i_i;
    end
    // off indicator kept as its own flop so the pin needs no gate
    s_nxt.out_off = !s_nxt.out_on;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.ctrl <= `PFS_CTRL_RESET;
      s_r.cause <= pfs_pkg::pfs_none;
      s_r.out_off <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // all outputs straight from the state register
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.rdat;
  assign output_on_o = s_r.out_on;
  assign led_prot_o = s_r.latched;
  assign led_off_o = s_r.out_off;
  assign buzzer_o = s_r.buzz;
  assign disp_cause_o = 3'(s_r.cause);
  assign disp_v_o = s_r.hold_v;
  assign disp_i_o = s_r.hold_i;
  assign disp_fault_o = s_r.latched;
endmodule : pfs_supervisor
`default_nettype wire

// ### src/pfs_params.svh
// timing counts and fixed thresholds of the protection supervisor
// assumes a 25 MHz system clock and signed meter words from the power stage
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH
`define PFS_CLK_HZ 25000000
`define PFS_TICK_US 1000
`define PFS_TICK_CYC ((`PFS_CLK_HZ / 1000000) * `PFS_TICK_US)
`define PFS_SENSE_MS 500
`define PFS_SENSE_TICKS (`PFS_SENSE_MS * 1000 / `PFS_TICK_US)
`define PFS_OT_DEGC 90
`define PFS_ADR_CTRL 32'h0000_0000
`define PFS_ADR_OC_LIM 32'h0000_0004
`define PFS_ADR_OP_LIM 32'h0000_0008
`define PFS_ADR_UV_LIM 32'h0000_000c
`define PFS_ADR_OC_DLY 32'h0000_0010
`define PFS_ADR_OP_DLY 32'h0000_0014
`define PFS_ADR_UV_DLY 32'h0000_0018
`define PFS_ADR_UV_WARM 32'h0000_001c
`define PFS_ADR_SENSE_TH 32'h0000_0020
`define PFS_ADR_CMD 32'h0000_0024
`define PFS_ADR_STATUS 32'h0000_0028
`define PFS_ADR_METER_V 32'h0000_002c
`define PFS_ADR_METER_I 32'h0000_0030
`define PFS_ADR_METER_P 32'h0000_0034
`define PFS_CTRL_OC_EN 0
`define PFS_CTRL_OP_EN 1
`define PFS_CTRL_UV_EN 2
`define PFS_CTRL_BEEP_EN 3
`define PFS_CTRL_SENSE_ON 4
`define PFS_CMD_CLEAR 0
`define PFS_CMD_OUT_ON 1
`define PFS_CMD_OUT_OFF 2
`define PFS_CTRL_RESET 32'h0000_0008
`endif

// ### src/pfs_pkg.sv
// types of the protection supervisor
// used with pfs_params.svh for numeric constants
package pfs_pkg;
  typedef enum logic [2:0] {
    pfs_none,
    pfs_overcurrent,
    pfs_overpower,
    pfs_undervoltage,
    pfs_overtemp,
    pfs_sense_err
  } pfs_cause_t;
endpackage : pfs_pkg

// ### testbench/pfs_properties.sv
// port checker for pfs_supervisor
// bound from tb; sees only the top module's ports
`include "pfs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pfs_properties #(parameter int TW = 12) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [TW-1:0] temp_degc_i,
  input wire logic fault_clear_input_i,
  input wire logic key_esc_i,
  input wire logic key_enter_i,
  input wire logic key_onoff_i,
  input wire logic output_on_o,
  input wire logic led_prot_o,
  input wire logic led_off_o,
  input wire logic buzzer_o,
  input wire logic [2:0] disp_cause_o,
  input wire logic disp_fault_o
);
  logic [3:0] qc_r;
  logic [3:0] qo_r;
  wire logic wr = wb_cyc_i && wb_stb_i && wb_we_i;
  // quiet time since a clear or switch-on source moved; six cycles outlast the key sync
  always_ff @(posedge clk_i) begin
    qc_r <= (rst_i || wr || fault_clear_input_i || key_esc_i || key_enter_i) ? 4'h0 : qc_r + 4'(qc_r != 4'hf);
    qo_r <= (rst_i || wr || key_onoff_i) ? 4'h0 : qo_r + 4'(qo_r != 4'hf);
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence hot_s; temp_degc_i > `PFS_OT_DEGC; endsequence
  ack_next_a: assert property (req_s |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  trip_off_a: assert property ($rose(led_prot_o) |-> !output_on_o && led_off_o) else $error("trip kept on");
  buzz_fault_a: assert property (buzzer_o |-> led_prot_o) else $error("stray buzzer");
  fault_show_a: assert property (led_prot_o |-> disp_fault_o && disp_cause_o != 3'h0) else $error("no cause");
  fault_hold_a: assert property (led_prot_o && qc_r > 4'h5 && !wr |=> led_prot_o) else $error("fault dropped");
  on_cause_a: assert property (qo_r > 4'h5 && !wr |=> !$rose(output_on_o)) else $error("output on unasked");
  hot_trip_a: assert property (hot_s |-> ##[1:3] (led_prot_o && !output_on_o)) else $error("hot kept on");
endmodule : pfs_properties
`default_nettype wire

// ### testbench/pfs_stage_model.sv
// power stage model: meters and terminal voltage
// levels come from tb; a lead gap shows only while switched on
`timescale 1ns/1ps
`default_nettype none
module pfs_stage_model (
  input wire logic out_on_i,
  input wire logic signed [23:0] v_i,
  input wire logic signed [23:0] i_i,
  input wire logic signed [23:0] p_i,
  input wire logic signed [23:0] gap_i,
  output logic signed [23:0] meter_v_o,
  output logic signed [23:0] meter_i_o,
  output logic signed [23:0] meter_p_o,
  output logic signed [23:0] term_v_o
);
  // meters follow an external source even with the switch open
  assign meter_v_o = v_i;
  assign meter_i_o = i_i;
  assign meter_p_o = p_i;
  assign term_v_o = out_on_i ? v_i + gap_i : v_i;
endmodule : pfs_stage_model
`default_nettype wire

// ### testbench/tb.sv
// bench: supervisor with stage model, one task per scenario
// tick shortened to 4 cycles; all delays scale from it
`include "pfs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack, on, prot, off, buzz, dfl;
  logic [31:0] adr = 32'h0, dat = 32'h0, rd, q;
  logic [3:0] btn = 4'h0;
  logic [11:0] temp = 12'h019;
  logic [2:0] cause;
  logic signed [23:0] v = 24'h0, i = 24'h0, p = 24'h0, gap = 24'h0, dv, di, mv, mi, mp, tv;
  int fail_count = 0, cmp_count = 0;
  initial forever #20 clk_i = ~clk_i;
  pfs_supervisor #(.TICK_CYC(4)) pfs_supervisor_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(rd), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack),
    .meter_v_i(mv), .meter_i_i(mi), .meter_p_i(mp), .term_v_i(tv), .temp_degc_i(temp),
    .fault_clear_input_i(btn[0]), .key_esc_i(btn[1]), .key_enter_i(btn[2]), .key_onoff_i(btn[3]),
    .output_on_o(on), .led_prot_o(prot), .led_off_o(off), .buzzer_o(buzz), .disp_cause_o(cause),
    .disp_v_o(dv), .disp_i_o(di), .disp_fault_o(dfl));
  pfs_stage_model pfs_stage_model_i (.out_on_i(on), .v_i(v), .i_i(i), .p_i(p), .gap_i(gap),
    .meter_v_o(mv), .meter_i_o(mi), .meter_p_o(mp), .term_v_o(tv));
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) fail_count++;
    if (s !== e) $display("MISMATCH %0t seen %h exp %h", $time, s, e);
  endtask : chk
  // one classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    for (n = 0; n < 9 && ack !== 1'b1; n++) @(posedge clk_i);
    if (n == 9) fail_count++;
    if (n == 9) finish_test();
    q = rd;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic press(input int k);
    btn[k] <= 1'b1;
    repeat (4) @(posedge clk_i);
    btn[k] <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : press
  // bounded wait for a trip, then one cycle for the display to settle
  task automatic wait_prot(input int lim);
    int n;
    for (n = 0; n < lim && prot !== 1'b1; n++) @(posedge clk_i);
    if (n == lim) fail_count++;
    if (n == lim) finish_test();
    @(posedge clk_i);
  endtask : wait_prot
  task automatic s_oc;
    wb(1'b1, `PFS_ADR_OC_LIM, 32'hffff_ff9c);
    wb(1'b1, `PFS_ADR_OC_DLY, 32'h2);
    wb(1'b1, `PFS_ADR_CTRL, 32'h9);
    wb(1'b1, `PFS_ADR_CMD, 32'h2);
    // two short bursts whose sum would outlast the delay
    repeat (2) begin
      i <= 24'hffff6a;
      repeat (6) @(posedge clk_i);
      i <= 24'h000032;
      repeat (2) @(posedge clk_i);
    end
    repeat (20) @(posedge clk_i);
    chk(prot, 1'b0);
    i <= 24'hffff6a;
    wait_prot(40);
    chk({cause, on, off, buzz}, {3'h1, 3'b011});
    i <= 24'h000032;
    repeat (30) @(posedge clk_i);
    chk({prot, dfl, di}, {2'b11, 24'h000032});
    chk(dv, 32'h0);
    press(0);
    chk({prot, on, cause}, 5'h0);
  endtask : s_oc
  task automatic s_op;
    wb(1'b1, `PFS_ADR_OP_LIM, 32'h0000_00c8);
    wb(1'b1, `PFS_ADR_OP_DLY, 32'h1);
    wb(1'b1, `PFS_ADR_CTRL, 32'h2);
    press(3);
    chk(on, 1'b1);
    i <= 24'hffff6a;
    p <= 24'hfffed4;
    wait_prot(40);
    chk({cause, on, buzz}, {3'h2, 2'b00});
    i <= 24'h000032;
    p <= 24'h0;
    press(1);
    chk(prot, 1'b0);
  endtask : s_op
  task automatic s_uv;
    wb(1'b1, `PFS_ADR_UV_LIM, 32'h0000_03e8);
    wb(1'b1, `PFS_ADR_UV_DLY, 32'h1);
    wb(1'b1, `PFS_ADR_UV_WARM, 32'h5);
    wb(1'b1, `PFS_ADR_CTRL, 32'h4);
    v <= 24'h0001f4;
    wb(1'b1, `PFS_ADR_CMD, 32'h2);
    repeat (16) @(posedge clk_i);
    chk({prot, on}, 2'b01);
    wait_prot(40);
    chk(cause, 3'h3);
    chk(dv, 32'h0000_01f4);
    v <= 24'h0007d0;
    press(2);
    chk(prot, 1'b0);
  endtask : s_uv
  task automatic s_ot;
    wb(1'b1, `PFS_ADR_CTRL, 32'h0);
    wb(1'b1, `PFS_ADR_CMD, 32'h2);
    temp <= 12'h05a;
    repeat (6) @(posedge clk_i);
    chk(prot, 1'b0);
    temp <= 12'h05b;
    wait_prot(4);
    chk({cause, on}, {3'h4, 1'b0});
    temp <= 12'h019;
    wb(1'b1, `PFS_ADR_CMD, 32'h1);
    chk(prot, 1'b0);
  endtask : s_ot
  task automatic s_sense;
    wb(1'b1, `PFS_ADR_SENSE_TH, 32'h32);
    wb(1'b1, `PFS_ADR_CTRL, 32'h10);
    gap <= 24'h000064;
    wb(1'b1, `PFS_ADR_CMD, 32'h2);
    repeat (`PFS_SENSE_TICKS * 4 - 200) @(posedge clk_i);
    chk(prot, 1'b0);
    wait_prot(400);
    chk({cause, on}, {3'h5, 1'b0});
  endtask : s_sense
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `PFS_ADR_CTRL, 32'h0);
    chk(q, `PFS_CTRL_RESET);
    chk({on, off}, 2'b01);
    wb(1'b0, 32'h0000_0040, 32'h0);
    chk(q, 32'h0);
    s_oc();
    s_op();
    s_uv();
    s_ot();
    s_sense();
    finish_test();
  end
endmodule : tb
bind pfs_supervisor pfs_properties #(.TW(TW)) pfs_properties_i (.clk_i(clk_i), .rst_i(rst_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .temp_degc_i(temp_degc_i),
  .fault_clear_input_i(fault_clear_input_i), .key_esc_i(key_esc_i), .key_enter_i(key_enter_i),
  .key_onoff_i(key_onoff_i), .output_on_o(output_on_o), .led_prot_o(led_prot_o), .led_off_o(led_off_o),
  .buzzer_o(buzzer_o), .disp_cause_o(disp_cause_o), .disp_fault_o(disp_fault_o));
`default_nettype wire
